// ===== bench/samc_host_model.sv
// Purpose: Scanner controller model loading control registers serially
// Assumes: Frame is select code then data byte, MSB first, load rise commits
// Notes:   Serial clock stands low outside frames; load idles high
`timescale 1ns/1ps
`default_nettype none
module samc_host_model (
    output var logic sclk,
    output var logic sdata,
    output var logic load
);
    initial
    begin
        sclk  = 1'b0;
        sdata = 1'b0;
        load  = 1'b1;
    end

    // Shift the top nBits of the frame, 80 ns per serial bit
    // Short frames are only sent when a refusal is wanted
    task automatic send(input logic [10:0] frame, input int nBits);
        int i;
        load = 1'b0;
        sclk = 1'b0;
        #40;
        for (i = 10; i > 10 - nBits; i--)
        begin
            sdata = frame[i]; // Select code first, MSB first
            #40;
            sclk = 1'b1;
            #40;
            sclk = 1'b0;
        end
        #40;
        load = 1'b1;
        // Released data line must not keep its last value
        sdata = ~sdata;
        // Load stands high a bit time so the next frame sees its fall
        #80;
    endtask : send
endmodule : samc_host_model
`default_nettype wire

// ===== bench/samc_mode_regs_tb.sv
// Purpose: Self-checking bench for the mode control register bank
// Assumes: Register updates settle within 7 clocks of the load rise
// Notes:   Expected values come from a shadow model kept by the driver
`timescale 1ns/1ps
`default_nettype none
module samc_mode_regs_tb;
    typedef struct packed {
        logic [7:0] mode;
        logic [7:0] mt;
    } samc_exp_s;

    logic                 clock = 1'b0;
    logic                 rst   = 1'b1;
    logic [7:0]           pixelIn = 8'h00;
    wire logic [7:0]      dbIn;
    logic [7:0]           dbOut;
    logic [7:0]           dbOe;
    samc_pkg::samc_ctrl_s ctrl;
    logic [7:0]           modeReadback;
    logic [7:0]           modeTestReadback;
    logic                 sclk;
    logic                 sdata;
    logic                 load;
    samc_exp_s            expQ[$];
    samc_exp_s            shadow;
    int                   miscompares = 0;
    int                   check_count = 0;
    int                   cycleCount = 0;
    logic [7:0]           d;
    logic [7:0]           pixExp = 8'h00;
    logic [7:0]           pixQ[$];

    always #4 clock = ~clock;

    // Host driver wins the shared upper pins; low pins pulled up if released
    assign dbIn[7:5] = {load, sdata, sclk};
    assign dbIn[4:0] = (dbOe[4:0] & dbOut[4:0]) | ~dbOe[4:0];

    samc_mode_regs #(.PIX_W(8)) i_dut (
        .clock            (clock),
        .rst              (rst),
        .pixelIn          (pixelIn),
        .dbIn             (dbIn),
        .dbOut            (dbOut),
        .dbOe             (dbOe),
        .ctrl             (ctrl),
        .modeReadback     (modeReadback),
        .modeTestReadback (modeTestReadback)
    );

    samc_host_model i_host (
        .sclk  (sclk),
        .sdata (sdata),
        .load  (load)
    );

    // Random pixel codes; note the code due on dbOut at the next edge
    always @(posedge clock)
    begin
        #1 pixelIn = 8'($urandom());
        // Power-down freezes the output flop, so the old code stays due
        if (!ctrl.powerDown)
            pixExp = pixelIn;
        if (cycleCount > 6)
            pixQ.push_back(pixExp);
    end

    // Pixel watcher: the newest note is still ahead of the output flop
    always @(posedge clock)
    begin
        #2;
        if (pixQ.size() > 1)
            checkVal("dbout", 32'(pixQ.pop_front()), 32'(dbOut));
    end

    task automatic checkVal(string name, logic [31:0] exp, logic [31:0] got);
        check_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask : checkVal

    // Full register and decoded-control comparison
    task automatic checkRegs(samc_exp_s e);
        samc_pkg::samc_ctrl_s c;
        c = '0;
        c.powerDown                   = e.mode[7];
        c.vrefExternal                = e.mode[5];
        c.dcrefExternal               = e.mode[4];
        c.acCoupled                   = e.mode[3];
        c.inputInverted               = e.mode[2];
        c.chanCfg                     = samc_pkg::samc_chan_e'(e.mode[1:0]);
        c.busControl                  = e.mt[7];
        c.outputDisable               = e.mt[6];
        c.dacRangeLow                 = e.mt[5];
        c.cisRefEnable                = e.mt[4];
        c.buffer_output_to_blue_probe = e.mt[3];
        c.amp_output_to_dcref_probe   = e.mt[2];
        c.adc_input_to_green_probe    = e.mt[1];
        c.first_diag_enable           = e.mt[0];
        checkVal("mode", 32'(e.mode), 32'(modeReadback));
        checkVal("modetest", 32'(e.mt), 32'(modeTestReadback));
        checkVal("ctrl", 32'(c), 32'(ctrl));
        checkVal("oe", 32'({8{~e.mt[6]}}), 32'(dbOe));
    endtask : checkRegs

    // Update the shadow, note the expectation, then send the frame
    task automatic writeReg(logic [2:0] sel, logic [7:0] data, int nBits);
        if (nBits >= 11 && sel == samc_pkg::SEL_MODE)
        begin
            if (data[6])
                shadow = '0;
            else
                shadow.mode = {data[7], 1'b0, data[5:2],
                               data[7] ? 2'b00 : data[1:0]};
        end
        else if (nBits >= 11 && sel == samc_pkg::SEL_MODE_TEST)
            shadow.mt = data;
        expQ.push_back(shadow);
        i_host.send({sel, data}, nBits);
    endtask : writeReg

    // Result watcher: one noted expectation per load rise
    initial
    begin
        wait (rst == 1'b0);
        forever
        begin
            @(posedge load);
            repeat (7) @(posedge clock);
            #1;
            if (expQ.size() > 0)
                checkRegs(expQ.pop_front());
        end
    end

    task automatic print_verdict();
        $display("Counts: %0d checks, %0d mismatches", check_count,
                 miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : print_verdict

    // Hang guard, far above the few thousand cycles the tests need
    always @(posedge clock)
    begin
        cycleCount++;
        if (cycleCount == 20000)
        begin
            miscompares++;
            print_verdict();
        end
    end

    initial
    begin
        void'($urandom(34));
        shadow = '0;
        repeat (5) @(posedge clock);
        #1 rst = 1'b0;
        repeat (4) @(posedge clock);
        #1 checkRegs(shadow);
        $display("test reset done");
        // Every channel scheme, random reference and polarity bits
        for (int k = 0; k < 4; k++)
        begin
            d = 8'($urandom()) & 8'h3C | 8'(k);
            writeReg(samc_pkg::SEL_MODE, d, 11);
        end
        $display("test mode fields done");
        // Host keeps output bus control at 1; disable toggled both ways
        for (int k = 0; k < 4; k++)
        begin
            d = {1'b1, k[0], 6'($urandom())};
            writeReg(samc_pkg::SEL_MODE_TEST, d, 11);
        end
        $display("test mode-test fields done");
        // Other select codes belong to other registers here
        for (int s = 0; s < 6; s++)
            writeReg(3'(s), 8'($urandom()), 11);
        writeReg(samc_pkg::SEL_MODE_TEST, 8'h80 | 8'($urandom()), 10);
        $display("test refused frames done");
        // Power-down keeps everything but the channel scheme
        d = 8'h83 | 8'($urandom()) & 8'h3C;
        writeReg(samc_pkg::SEL_MODE, d, 11);
        writeReg(samc_pkg::SEL_MODE, 8'h22, 11);
        $display("test power-down done");
        // Soft reset returns both registers to power-up values
        writeReg(samc_pkg::SEL_MODE_TEST, 8'hBF, 11);
        d = 8'h40 | 8'($urandom()) & 8'hBF;
        writeReg(samc_pkg::SEL_MODE, d, 11);
        $display("test soft reset done");
        while (expQ.size() > 0)
            @(posedge clock);
        repeat (2) @(posedge clock);
        print_verdict();
    end
endmodule : samc_mode_regs_tb
`default_nettype wire

// ===== hw/samc_mode_regs.sv
// Purpose: Mode and mode-and-test control registers of the sensor front end
// Assumes: Host loads registers serially over the shared upper data pins
// Notes:   Gain and offset registers are outside this block
`timescale 1ns/1ps
`default_nettype none
module samc_mode_regs #(
    parameter int PIX_W = 8
) (
    input  wire logic               clock,
    input  wire logic               rst,
    input  wire logic [PIX_W-1:0]   pixelIn,
    input  wire logic [PIX_W-1:0]   dbIn,
    output logic      [PIX_W-1:0]   dbOut,
    output logic      [PIX_W-1:0]   dbOe,
    output samc_pkg::samc_ctrl_s    ctrl,
    output logic      [7:0]         modeReadback,
    output logic      [7:0]         modeTestReadback
);
    logic                  frameValid;
    samc_pkg::samc_frame_s frame;
    logic [7:0]            mode_reg;
    logic [7:0]            modeTest_reg;
    logic [7:0]            mode_next;
    logic [PIX_W-1:0]      pixel_reg;
    logic                  wrMode;
    logic                  wrTest;

    // Upper three data pins double as serial clock, data and load
    samc_serial_rx u_rx (
        .clock      (clock),
        .rst        (rst),
        .sclkPin    (dbIn[5]),
        .sdataPin   (dbIn[6]),
        .loadPin    (dbIn[7]),
        .frameValid (frameValid),
        .frame      (frame)
    );

    // Select decode; other codes belong to gain and offset banks
    assign wrMode = frameValid && (frame.sel == samc_pkg::SEL_MODE);
    assign wrTest = frameValid
                 && (frame.sel == samc_pkg::SEL_MODE_TEST);

    // Mode write value: reset bit never sticks, power-down drops config
    always_comb
    begin
        mode_next = frame.data;
        mode_next[samc_pkg::MODE_SRST] = 1'b0;
        if (frame.data[samc_pkg::MODE_PDN])
        begin
            mode_next[samc_pkg::MODE_CFG_HI] = 1'b0;
            mode_next[samc_pkg::MODE_CFG_LO] = 1'b0;
        end
    end

    // Operating mode register
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            mode_reg <= samc_pkg::MODE_RESET;
        end
        else if (wrMode && frame.data[samc_pkg::MODE_SRST])
        begin
            mode_reg <= samc_pkg::MODE_RESET;
        end
        else if (wrMode)
        begin
            mode_reg <= mode_next;
        end
    end

    // Mode-and-test register; soft reset in the mode register clears it too
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            modeTest_reg <= samc_pkg::MODE_TEST_RESET;
        end
        else if (wrMode && frame.data[samc_pkg::MODE_SRST])
        begin
            modeTest_reg <= samc_pkg::MODE_TEST_RESET;
        end
        else if (wrTest)
        begin
            modeTest_reg <= frame.data;
        end
    end

    // Decoded controls, straight from the register flops
    always_comb
    begin
        ctrl.powerDown     = mode_reg[samc_pkg::MODE_PDN];
        ctrl.vrefExternal  = mode_reg[samc_pkg::MODE_VRT];
        ctrl.dcrefExternal = mode_reg[samc_pkg::MODE_DCREF];
        ctrl.acCoupled     = mode_reg[samc_pkg::MODE_AC];
        ctrl.inputInverted = mode_reg[samc_pkg::MODE_INV];
        ctrl.chanCfg       = samc_pkg::samc_chan_e'(
            mode_reg[samc_pkg::MODE_CFG_HI:samc_pkg::MODE_CFG_LO]);
        ctrl.busControl    = modeTest_reg[samc_pkg::MT_BUSCTL];
        ctrl.outputDisable = modeTest_reg[samc_pkg::MT_OUTDIS];
        ctrl.dacRangeLow   = modeTest_reg[samc_pkg::MT_DACRNG];
        ctrl.cisRefEnable  = modeTest_reg[samc_pkg::MT_CISREF];
        ctrl.buffer_output_to_blue_probe =
            modeTest_reg[samc_pkg::MT_BLUPRB];
        ctrl.amp_output_to_dcref_probe =
            modeTest_reg[samc_pkg::MT_DCRPRB];
        ctrl.adc_input_to_green_probe =
            modeTest_reg[samc_pkg::MT_GRNPRB];
        ctrl.first_diag_enable = modeTest_reg[samc_pkg::MT_DIAG];
    end

    assign modeReadback     = mode_reg;
    assign modeTestReadback = modeTest_reg;

    // Pixel output register; frozen in power-down to save toggling
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            pixel_reg <= '0;
        end
        else if (!mode_reg[samc_pkg::MODE_PDN])
        begin
            pixel_reg <= pixelIn;
        end
    end

    // Host must disable outputs before driving the shared serial pins
    assign dbOut = pixel_reg;
    assign dbOe  = {PIX_W{~modeTest_reg[samc_pkg::MT_OUTDIS]}};

    // Checks
    property p_pdn_set;
        @(posedge clock) disable iff (rst)
        wrMode && frame.data[samc_pkg::MODE_PDN]
            && !frame.data[samc_pkg::MODE_SRST]
            |=> ctrl.powerDown && ctrl.chanCfg == samc_pkg::CHAN_SINGLE_RED;
    endproperty
    a_pdn_set: assert property (p_pdn_set)
        else $error("power-down write not applied");

    property p_srst;
        @(posedge clock) disable iff (rst)
        wrMode && frame.data[samc_pkg::MODE_SRST]
            |=> mode_reg == samc_pkg::MODE_RESET
            && modeTest_reg == samc_pkg::MODE_TEST_RESET;
    endproperty
    a_srst: assert property (p_srst)
        else $error("soft reset did not restore power-up values");

    property p_no_srst;
        @(posedge clock) disable iff (rst)
        wrMode && !frame.data[samc_pkg::MODE_SRST]
            |=> $stable(modeTest_reg) && !mode_reg[samc_pkg::MODE_SRST];
    endproperty
    a_no_srst: assert property (p_no_srst)
        else $error("write without reset disturbed registers");

    property p_mode_fields;
        @(posedge clock) disable iff (rst)
        wrMode && frame.data[7:6] == 2'h0 |=>
            ctrl.vrefExternal == $past(frame.data[5])
            && ctrl.dcrefExternal == $past(frame.data[4])
            && ctrl.inputInverted == $past(frame.data[2])
            && ctrl.chanCfg == $past(frame.data[1:0]);
    endproperty
    a_mode_fields: assert property (p_mode_fields)
        else $error("mode fields do not follow written byte");

    property p_test_fields;
        @(posedge clock) disable iff (rst)
        wrTest |=> modeTestReadback == $past(frame.data)
            && dbOe == {PIX_W{~$past(frame.data[6])}}
            && ctrl.first_diag_enable == $past(frame.data[0]);
    endproperty
    a_test_fields: assert property (p_test_fields)
        else $error("mode-and-test fields do not follow written byte");

    property p_pdn_cfg;
        @(posedge clock) disable iff (rst)
        ctrl.powerDown |-> ctrl.chanCfg == samc_pkg::CHAN_SINGLE_RED;
    endproperty
    a_pdn_cfg: assert property (p_pdn_cfg)
        else $error("channel configuration survived power-down");

    property p_pdn_keep;
        @(posedge clock) disable iff (rst)
        wrMode && frame.data[samc_pkg::MODE_PDN]
            && !frame.data[samc_pkg::MODE_SRST]
            |=> $stable(modeTest_reg)
            && mode_reg[samc_pkg::MODE_VRT:samc_pkg::MODE_INV]
               == $past(frame.data[samc_pkg::MODE_VRT:samc_pkg::MODE_INV]);
    endproperty
    a_pdn_keep: assert property (p_pdn_keep)
        else $error("power-down lost a register value");

    property p_no_frame;
        @(posedge clock) disable iff (rst)
        !frameValid |=> $stable(mode_reg) && $stable(modeTest_reg);
    endproperty
    a_no_frame: assert property (p_no_frame)
        else $error("register changed without a loaded frame");

    property p_other_sel;
        @(posedge clock) disable iff (rst)
        frameValid && frame.sel[2:1] != 2'h3
            |=> $stable(mode_reg) && $stable(modeTest_reg);
    endproperty
    a_other_sel: assert property (p_other_sel)
        else $error("foreign select code changed a register");

    c_pdn:   cover property (@(posedge clock) disable iff (rst)
        wrMode ##1 ctrl.powerDown);
    c_srst:  cover property (@(posedge clock) disable iff (rst)
        wrMode && frame.data[6]);
    c_test:  cover property (@(posedge clock) disable iff (rst)
        wrTest ##1 ctrl.busControl);
    c_cycle: cover property (@(posedge clock) disable iff (rst)
        ctrl.chanCfg == samc_pkg::CHAN_TRIPLE_PER_LINE);

endmodule : samc_mode_regs
`default_nettype wire

// ===== hw/samc_serial_rx.sv
// Purpose: Three-wire serial receiver for control register writes
// Assumes: Serial clock, data and load arrive from pins, asynchronous
// Notes:   Pins are oversampled; serial clock must be slow against clock
`timescale 1ns/1ps
`default_nettype none
module samc_serial_rx (
    input  wire logic                 clock,
    input  wire logic                 rst,
    input  wire logic                 sclkPin,
    input  wire logic                 sdataPin,
    input  wire logic                 loadPin,
    output logic                      frameValid,
    output samc_pkg::samc_frame_s     frame
);
    localparam int FW = samc_pkg::FRAME_BITS;
    // Idle pin levels {load, data, clock}: load high, others low
    localparam logic [2:0] PIN_IDLE = 3'h4;

    logic [2:0]    syncA_reg;
    logic [2:0]    syncB_reg;
    logic          sclkLast_reg;
    logic          loadLast_reg;
    logic [FW-1:0] shift_reg;
    logic [3:0]    count_reg;
    logic          sclkRise;
    logic          loadRise;

    // Two-stage synchronisers; only syncB is read by logic
    // Reset to idle levels so release gives no false load edge
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            syncA_reg <= PIN_IDLE;
            syncB_reg <= PIN_IDLE;
        end
        else
        begin
            syncA_reg <= {loadPin, sdataPin, sclkPin};
            syncB_reg <= syncA_reg;
        end
    end

    // Edge history of serial clock and load
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            sclkLast_reg <= PIN_IDLE[0];
            loadLast_reg <= PIN_IDLE[2];
        end
        else
        begin
            sclkLast_reg <= syncB_reg[0];
            loadLast_reg <= syncB_reg[2];
        end
    end

    assign sclkRise = syncB_reg[0] & ~sclkLast_reg;
    assign loadRise = syncB_reg[2] & ~loadLast_reg;

    // Shift while load is low; count saturates so extra bits keep last 11
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            shift_reg <= '0;
            count_reg <= 4'h0;
        end
        else if (loadRise)
        begin
            count_reg <= 4'h0;
        end
        else if (sclkRise && !syncB_reg[2])
        begin
            shift_reg <= {shift_reg[FW-2:0], syncB_reg[1]};
            if (count_reg < 4'(FW))
            begin
                count_reg <= count_reg + 4'h1;
            end
        end
    end

    // Frame is released only on load with a full frame shifted
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            frameValid <= 1'b0;
            frame      <= '0;
        end
        else
        begin
            frameValid <= loadRise && (count_reg == 4'(FW));
            if (loadRise)
            begin
                frame <= shift_reg;
            end
        end
    end

endmodule : samc_serial_rx
`default_nettype wire

// ===== include/samc_pkg.sv
// Purpose: Shared constants and types for the sensor front-end mode registers
// Assumes: Serial frame is a 3-bit select code followed by an 8-bit data byte
// Notes:   Only the mode and mode-and-test registers live in this block
`default_nettype none
package samc_pkg;

    // Serial frame layout, select code first, most significant bit first
    localparam int        SEL_W      = 3;
    localparam int        DATA_W     = 8;
    localparam int        FRAME_BITS = SEL_W + DATA_W;

    // Register select codes
    localparam logic [2:0] SEL_MODE      = 3'h6;
    localparam logic [2:0] SEL_MODE_TEST = 3'h7;

    // Power-up values
    localparam logic [7:0] MODE_RESET      = 8'h00;
    localparam logic [7:0] MODE_TEST_RESET = 8'h00;

    // Operating mode register bit positions
    localparam int MODE_PDN    = 7;
    localparam int MODE_SRST   = 6;
    localparam int MODE_VRT    = 5;
    localparam int MODE_DCREF  = 4;
    localparam int MODE_AC     = 3;
    localparam int MODE_INV    = 2;
    localparam int MODE_CFG_HI = 1;
    localparam int MODE_CFG_LO = 0;

    // Mode-and-test register bit positions
    localparam int MT_BUSCTL = 7;
    localparam int MT_OUTDIS = 6;
    localparam int MT_DACRNG = 5;
    localparam int MT_CISREF = 4;
    localparam int MT_BLUPRB = 3;
    localparam int MT_DCRPRB = 2;
    localparam int MT_GRNPRB = 1;
    localparam int MT_DIAG   = 0;

    // Channel sequencing schemes, in field-code order 00..11
    typedef enum logic [1:0] {
        CHAN_SINGLE_RED,
        CHAN_RGB_PER_PIXEL,
        CHAN_TRIPLE_PER_PIXEL,
        CHAN_TRIPLE_PER_LINE
    } samc_chan_e;

    // One received serial write
    typedef struct packed {
        logic [SEL_W-1:0]  sel;
        logic [DATA_W-1:0] data;
    } samc_frame_s;

    // Decoded controls handed to the analog side
    typedef struct packed {
        logic       powerDown;
        logic       vrefExternal;
        logic       dcrefExternal;
        logic       acCoupled;
        logic       inputInverted;
        samc_chan_e chanCfg;
        logic       busControl;
        logic       outputDisable;
        logic       dacRangeLow;
        logic       cisRefEnable;
        logic       buffer_output_to_blue_probe;
        logic       amp_output_to_dcref_probe;
        logic       adc_input_to_green_probe;
        logic       first_diag_enable;
    } samc_ctrl_s;

endpackage : samc_pkg
`default_nettype wire
